// file: verilog/rmms_cfg.svh
`ifndef RMMS_CFG_SVH
`define RMMS_CFG_SVH

// Bus and data widths
`define RMMS_DW       32
`define RMMS_AW       12
`define RMMS_CNT_W    32
`define RMMS_LEN_W    16
`define RMMS_FEAT_W   8
`define RMMS_TOPO_W   8
`define RMMS_MT_W     8
`define RMMS_PER_W    2
`define RMMS_IDX_W    7

// Counter array shape
`define RMMS_NPT      4
`define RMMS_NERR     8
`define RMMS_NFLOW    7'h40
`define RMMS_NCNT     7'h48
`define RMMS_PER_NUM  2'h3

// Register byte offsets
`define RMMS_OFS_CTRL    12'h000
`define RMMS_OFS_STATUS  12'h004
`define RMMS_OFS_EVENT   12'h008
`define RMMS_OFS_FEAT    12'h00C
`define RMMS_OFS_TOPO    12'h010
`define RMMS_OFS_DISC    12'h014
`define RMMS_OFS_LAST    12'h018
`define RMMS_CNT_BASE    12'h400

// Field positions
`define RMMS_CTRL_ADMIN  0
`define RMMS_CTRL_CLEAR  1
`define RMMS_CTRL_TICK   2
`define RMMS_ST_OPER     0
`define RMMS_ST_ADMIN    1
`define RMMS_EVT_DUP     0
`define RMMS_EVT_DISC    1

// Reset values
`define RMMS_RST_ADMIN   1'b0
`define RMMS_RST_FEAT    8'h00
`define RMMS_RST_EVT     2'h0
`define RMMS_ZERO        32'h0000_0000
`define RMMS_ONE         32'h0000_0001

// Supported management frame codes, below these limits
`define RMMS_MGMT_TYPE_CNT 8'h03
`define RMMS_MGMT_FUNC_CNT 8'h01

`endif

// file: verilog/rmms_pkg.sv
`default_nettype none

package rmms_pkg;

	typedef enum logic [1:0] {
		CLASS_A,
		CLASS_B_COMMITTED,
		CLASS_B_EXCESS,
		CLASS_C
	} rmms_class_t;

	typedef enum logic [1:0] {
		PER_CURRENT,
		PER_PAST,
		PER_TOTAL
	} rmms_period_t;

	typedef enum logic {
		BUS_IDLE,
		BUS_RESP
	} rmms_bus_st_t;

endpackage : rmms_pkg

`default_nettype wire

// file: verilog/rmms_cnt_bank.sv
`include "rmms_cfg.svh"
`default_nettype none

module rmms_cnt_bank (
	input  wire logic                            clk_i,
	input  wire logic                            rst_i,
	input  wire logic [`RMMS_NPT-1:0]            frame_done_i,
	input  wire logic [`RMMS_NPT-1:0]            frame_mcast_i,
	input  wire logic [2*`RMMS_NPT-1:0]          frame_class_i,
	input  wire logic [`RMMS_LEN_W*`RMMS_NPT-1:0] frame_len_i,
	input  wire logic [`RMMS_NERR-1:0]           span_err_i,
	input  wire logic                            boundary_i,
	input  wire logic                            clear_i,
	input  wire rmms_pkg::rmms_period_t          rd_per_i,
	input  wire logic [`RMMS_IDX_W-1:0]          rd_idx_i,
	output logic      [`RMMS_CNT_W-1:0]          rd_data_o
);
	import rmms_pkg::*;

	logic [`RMMS_CNT_W-1:0] cur_q  [`RMMS_NCNT];
	logic [`RMMS_CNT_W-1:0] past_q [`RMMS_NCNT];
	logic [`RMMS_CNT_W-1:0] tot_q  [`RMMS_NCNT];

	////////////////////////////////////////////////////////////////////
	// Counters: index is {point, mcast, class, octets}, then errors
	genvar g;
	generate
		for (g = 0; g < `RMMS_NCNT; g++) begin : g_cnt
			logic [`RMMS_CNT_W-1:0] amt;
			logic [`RMMS_CNT_W-1:0] cur_d;
			logic [`RMMS_CNT_W-1:0] past_d;
			logic [`RMMS_CNT_W-1:0] tot_d;
			if (g < `RMMS_NFLOW) begin : g_flow
				localparam int PT = g / 16;
				localparam logic AD = 1'((g / 8) % 2);
				localparam rmms_class_t CL = rmms_class_t'(2'((g / 2) % 4));
				localparam logic UN = 1'(g % 2);
				always_comb begin
					amt = `RMMS_ZERO;
					if (frame_done_i[PT] && (frame_mcast_i[PT] == AD) &&
					    (rmms_class_t'(frame_class_i[2*PT +: 2]) == CL)) begin
						amt = UN ? `RMMS_CNT_W'(frame_len_i[PT*`RMMS_LEN_W +: `RMMS_LEN_W])
						         : `RMMS_ONE;
					end
				end
			end else begin : g_err
				always_comb begin
					amt = `RMMS_CNT_W'(span_err_i[g - `RMMS_NFLOW]);
				end
			end
			always_comb begin
				cur_d  = cur_q[g] + amt;
				past_d = past_q[g];
				tot_d  = tot_q[g];
				if (clear_i) begin
					cur_d  = `RMMS_ZERO;
					past_d = `RMMS_ZERO;
					tot_d  = `RMMS_ZERO;
				end else if (boundary_i) begin
					past_d = cur_q[g];
					tot_d  = tot_q[g] + cur_q[g];
					cur_d  = amt;
				end
			end
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cur_q[g]  <= `RMMS_ZERO;
					past_q[g] <= `RMMS_ZERO;
					tot_q[g]  <= `RMMS_ZERO;
				end else begin
					cur_q[g]  <= cur_d;
					past_q[g] <= past_d;
					tot_q[g]  <= tot_d;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Read selection by period and index
	always_comb begin
		rd_data_o = `RMMS_ZERO;
		if (rd_idx_i < `RMMS_NCNT) begin
			case (rd_per_i)
				PER_CURRENT: rd_data_o = cur_q[rd_idx_i];
				PER_PAST:    rd_data_o = past_q[rd_idx_i];
				PER_TOTAL:   rd_data_o = tot_q[rd_idx_i];
				default:     rd_data_o = `RMMS_ZERO;
			endcase
		end
	end

endmodule : rmms_cnt_bank

`default_nettype wire

// file: verilog/rmms_mgmt_filter.sv
`include "rmms_cfg.svh"
`default_nettype none

module rmms_mgmt_filter (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  mgmt_valid_i,
	input  wire logic [`RMMS_MT_W-1:0] mgmt_frame_type_i,
	input  wire logic [`RMMS_MT_W-1:0] mgmt_func_i,
	output logic                       mgmt_accept_o,
	output logic                       mgmt_discard_o
);
	import rmms_pkg::*;

	logic ok;
	logic acc_d;
	logic acc_q;
	logic dis_d;
	logic dis_q;

	always_comb begin
		ok    = (mgmt_frame_type_i < `RMMS_MGMT_TYPE_CNT) &&
		        (mgmt_func_i < `RMMS_MGMT_FUNC_CNT);
		acc_d = mgmt_valid_i && ok;
		dis_d = mgmt_valid_i && !ok;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_q <= 1'b0;
			dis_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			dis_q <= dis_d;
		end
	end

	assign mgmt_accept_o  = acc_q;
	assign mgmt_discard_o = dis_q;

endmodule : rmms_mgmt_filter

`default_nettype wire

// file: verilog/rmms_mgmt_stats.sv
// The implementer's own choices: the address map and the Wishbone register port.
`include "rmms_cfg.svh"
`default_nettype none

module rmms_mgmt_stats (
	input  wire logic                             clk_i,
	input  wire logic                             rst_i,
	input  wire logic                             wb_cyc_i,
	input  wire logic                             wb_stb_i,
	input  wire logic                             wb_we_i,
	input  wire logic [`RMMS_AW-1:0]              wb_adr_i,
	input  wire logic [3:0]                       wb_sel_i,
	input  wire logic [`RMMS_DW-1:0]              wb_dat_i,
	output logic      [`RMMS_DW-1:0]              wb_dat_o,
	output logic                                  wb_ack_o,
	output logic                                  wb_err_o,
	input  wire logic [`RMMS_NPT-1:0]             frame_done_i,
	input  wire logic [`RMMS_NPT-1:0]             frame_mcast_i,
	input  wire logic [2*`RMMS_NPT-1:0]           frame_class_i,
	input  wire logic [`RMMS_LEN_W*`RMMS_NPT-1:0] frame_len_i,
	input  wire logic [`RMMS_NERR-1:0]            span_err_i,
	input  wire logic                             interval_tick_i,
	input  wire logic                             span_oper_i,
	input  wire logic                             keepalive_ok_i,
	input  wire logic                             peer_protect_i,
	input  wire logic                             dup_mac_i,
	input  wire logic [`RMMS_TOPO_W-1:0]          topo_state_i,
	input  wire logic                             mgmt_valid_i,
	input  wire logic [`RMMS_MT_W-1:0]            mgmt_frame_type_i,
	input  wire logic [`RMMS_MT_W-1:0]            mgmt_func_i,
	output logic                                  mgmt_accept_o,
	output logic                                  mgmt_discard_o,
	output logic                                  pass_enable_o,
	output logic                                  oper_up_o,
	output logic                                  misconfig_o,
	output logic      [`RMMS_FEAT_W-1:0]          feature_dis_o
);
	import rmms_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Address decode and byte lane mask helpers
	function automatic logic cnt_hit(input logic [`RMMS_AW-1:0] a);
		logic [`RMMS_AW-1:0] o;
		o = a - `RMMS_CNT_BASE;
		return (a >= `RMMS_CNT_BASE) && !o[11] && (o[1:0] == 2'h0) &&
		       (o[10:9] < `RMMS_PER_NUM) && (o[8:2] < `RMMS_NCNT);
	endfunction : cnt_hit

	function automatic logic [`RMMS_DW-1:0] lane_mask(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : lane_mask

	////////////////////////////////////////////////////////////////////
	// Declarations
	rmms_bus_st_t             st_d;
	rmms_bus_st_t             st_q;
	logic                     ack_d;
	logic                     ack_q;
	logic                     err_d;
	logic                     err_q;
	logic [`RMMS_DW-1:0]      rdat_d;
	logic [`RMMS_DW-1:0]      rdat_q;
	logic                     rd_ok;
	logic                     wr_ok;
	logic [`RMMS_DW-1:0]      rd_val;
	logic [`RMMS_AW-1:0]      cnt_ofs;
	logic [`RMMS_CNT_W-1:0]   cnt_data;
	logic                     wr_take;
	logic [`RMMS_DW-1:0]      wm;

	logic                     admin_d;
	logic                     admin_q;
	logic [`RMMS_FEAT_W-1:0]  feat_d;
	logic [`RMMS_FEAT_W-1:0]  feat_q;
	logic                     clr_d;
	logic                     clr_q;
	logic                     tick_d;
	logic                     tick_q;
	logic [1:0]               evt_d;
	logic [1:0]               evt_q;
	logic                     last_d;
	logic                     last_q;
	logic                     oper_d;
	logic                     oper_q;
	logic [`RMMS_CNT_W-1:0]   disc_d;
	logic [`RMMS_CNT_W-1:0]   disc_q;
	logic                     discard;

	////////////////////////////////////////////////////////////////////
	// Statistics counters
	assign cnt_ofs = wb_adr_i - `RMMS_CNT_BASE;

	rmms_cnt_bank u_cnt (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.frame_done_i  (frame_done_i),
		.frame_mcast_i (frame_mcast_i),
		.frame_class_i (frame_class_i),
		.frame_len_i   (frame_len_i),
		.span_err_i    (span_err_i),
		.boundary_i    (interval_tick_i || tick_q),
		.clear_i       (clr_q),
		.rd_per_i      (rmms_period_t'(cnt_ofs[10:9])),
		.rd_idx_i      (cnt_ofs[8:2]),
		.rd_data_o     (cnt_data)
	);

	////////////////////////////////////////////////////////////////////
	// Management frame filter
	rmms_mgmt_filter u_filt (
		.clk_i             (clk_i),
		.rst_i             (rst_i),
		.mgmt_valid_i      (mgmt_valid_i),
		.mgmt_frame_type_i (mgmt_frame_type_i),
		.mgmt_func_i       (mgmt_func_i),
		.mgmt_accept_o     (mgmt_accept_o),
		.mgmt_discard_o    (discard)
	);

	assign mgmt_discard_o = discard;

	////////////////////////////////////////////////////////////////////
	// Attribute read and write decode
	always_comb begin
		rd_ok  = 1'b1;
		wr_ok  = 1'b0;
		rd_val = `RMMS_ZERO;
		case (wb_adr_i)
			`RMMS_OFS_CTRL: begin
				rd_val[`RMMS_CTRL_ADMIN] = admin_q;
				wr_ok = 1'b1;
			end
			`RMMS_OFS_STATUS: begin
				rd_val[`RMMS_ST_OPER]  = oper_q;
				rd_val[`RMMS_ST_ADMIN] = admin_q;
			end
			`RMMS_OFS_EVENT: begin
				rd_val[1:0] = evt_q;
				wr_ok = 1'b1;
			end
			`RMMS_OFS_FEAT: begin
				rd_val[`RMMS_FEAT_W-1:0] = feat_q;
				wr_ok = 1'b1;
			end
			`RMMS_OFS_TOPO: begin
				rd_val[`RMMS_TOPO_W-1:0] = topo_state_i;
			end
			`RMMS_OFS_DISC: begin
				rd_val = disc_q;
			end
			`RMMS_OFS_LAST: begin
				rd_val[0] = last_q;
			end
			default: begin
				rd_ok  = cnt_hit(wb_adr_i);
				rd_val = cnt_data;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Wishbone slave handshake
	always_comb begin
		st_d   = st_q;
		ack_d  = 1'b0;
		err_d  = 1'b0;
		rdat_d = rdat_q;
		case (st_q)
			BUS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					st_d = BUS_RESP;
					if (wb_we_i) begin
						ack_d = wr_ok;
						err_d = !wr_ok;
					end else begin
						ack_d  = rd_ok;
						err_d  = !rd_ok;
						rdat_d = rd_ok ? rd_val : `RMMS_ZERO;
					end
				end
			end
			BUS_RESP: begin
				st_d = BUS_IDLE;
			end
			default: begin
				st_d = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q   <= BUS_IDLE;
			ack_q  <= 1'b0;
			err_q  <= 1'b0;
			rdat_q <= `RMMS_ZERO;
		end else begin
			st_q   <= st_d;
			ack_q  <= ack_d;
			err_q  <= err_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdat_q;

	////////////////////////////////////////////////////////////////////
	// Attribute store and write actions
	assign wr_take = (st_q == BUS_RESP) && ack_q && wb_we_i;
	assign wm      = lane_mask(wb_sel_i);

	always_comb begin
		admin_d = admin_q;
		feat_d  = feat_q;
		clr_d   = 1'b0;
		tick_d  = 1'b0;
		evt_d   = evt_q;
		last_d  = last_q;
		if (st_q == BUS_RESP) begin
			last_d = err_q;
		end
		if (wr_take) begin
			case (wb_adr_i)
				`RMMS_OFS_CTRL: begin
					if (wb_sel_i[0]) begin
						admin_d = wb_dat_i[`RMMS_CTRL_ADMIN];
						clr_d   = wb_dat_i[`RMMS_CTRL_CLEAR];
						tick_d  = wb_dat_i[`RMMS_CTRL_TICK];
					end
				end
				`RMMS_OFS_FEAT: begin
					if (wb_sel_i[0]) begin
						feat_d = wb_dat_i[`RMMS_FEAT_W-1:0];
					end
				end
				`RMMS_OFS_EVENT: begin
					evt_d = evt_q & ~(wb_dat_i[1:0] & wm[1:0]);
				end
				default: begin
					admin_d = admin_q;
				end
			endcase
		end
		if (dup_mac_i) begin
			evt_d[`RMMS_EVT_DUP] = 1'b1;
		end
		if (discard) begin
			evt_d[`RMMS_EVT_DISC] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			admin_q <= `RMMS_RST_ADMIN;
			feat_q  <= `RMMS_RST_FEAT;
			clr_q   <= 1'b0;
			tick_q  <= 1'b0;
			evt_q   <= `RMMS_RST_EVT;
			last_q  <= 1'b0;
		end else begin
			admin_q <= admin_d;
			feat_q  <= feat_d;
			clr_q   <= clr_d;
			tick_q  <= tick_d;
			evt_q   <= evt_d;
			last_q  <= last_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Operational state and discard count
	always_comb begin
		oper_d = span_oper_i && admin_q && keepalive_ok_i && !peer_protect_i;
		disc_d = disc_q + (discard ? `RMMS_ONE : `RMMS_ZERO);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oper_q <= 1'b0;
			disc_q <= `RMMS_ZERO;
		end else begin
			oper_q <= oper_d;
			disc_q <= disc_d;
		end
	end

	assign pass_enable_o = admin_q;
	assign oper_up_o     = oper_q;
	assign misconfig_o   = evt_q[`RMMS_EVT_DUP];
	assign feature_dis_o = feat_q;

endmodule : rmms_mgmt_stats

`default_nettype wire

// file: tb/rmms_station_mgr.sv
`default_nettype none
module rmms_station_mgr (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic        err_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [11:0]      adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 12'h000;
		sel_o = 4'hF;
		dat_o = 32'h0000_0000;
	end
	// One classic cycle naming an attribute, value out, status back
	task automatic xfer(input logic we, input logic [11:0] adr, input logic [31:0] wd,
		input logic [3:0] sl, output logic [31:0] rd, output logic er);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= we;
		adr_o <= adr;
		sel_o <= sl;
		dat_o <= wd;
		do begin
			@(posedge clk_i);
		end while (!(ack_i || err_i));
		rd = dat_i;
		er = err_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		dat_o <= ~wd;
		@(negedge clk_i);
	endtask : xfer
endmodule : rmms_station_mgr
`default_nettype wire

// file: tb/rmms_mgmt_stats_asserts.sv
`default_nettype none
module rmms_mgmt_stats_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        span_oper_i,
	input wire logic        keepalive_ok_i,
	input wire logic        peer_protect_i,
	input wire logic        dup_mac_i,
	input wire logic        mgmt_valid_i,
	input wire logic [7:0]  mgmt_frame_type_i,
	input wire logic [7:0]  mgmt_func_i,
	input wire logic        mgmt_accept_o,
	input wire logic        mgmt_discard_o,
	input wire logic        pass_enable_o,
	input wire logic        oper_up_o,
	input wire logic        misconfig_o,
	input wire logic [7:0]  feature_dis_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic req;
	logic good;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign good = (mgmt_frame_type_i < 8'h03) && (mgmt_func_i < 8'h01);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////
	a_answer_next: assert property (req |=> wb_ack_o || wb_err_o)
		else $error("request not answered next cycle");
	a_answer_excl: assert property (!(wb_ack_o && wb_err_o))
		else $error("ack and err together");
	a_answer_pulse: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
		else $error("answer longer than one cycle");
	a_read_err_zero: assert property (wb_err_o && !wb_we_i |-> wb_dat_o == 32'h0000_0000)
		else $error("errored read returned data");
	a_admin_cause: assert property ($changed(pass_enable_o) |->
		$past(wb_ack_o && wb_we_i && wb_adr_i == 12'h000))
		else $error("admin state changed without a control write");
	a_oper_derive: assert property (oper_up_o ==
		$past(span_oper_i && pass_enable_o && keepalive_ok_i && !peer_protect_i))
		else $error("oper state mismatch");
	a_dup_sticky: assert property (dup_mac_i |=> misconfig_o)
		else $error("duplicate address not flagged");
	a_feat_write: assert property (wb_ack_o && wb_we_i && wb_adr_i == 12'h00C && wb_sel_i[0]
		|=> feature_dis_o == $past(wb_dat_i[7:0]))
		else $error("feature disable not stored");
	a_mgmt_accept: assert property (mgmt_valid_i && good |=> mgmt_accept_o && !mgmt_discard_o)
		else $error("supported frame not accepted");
	a_mgmt_discard: assert property (mgmt_valid_i && !good |=> mgmt_discard_o && !mgmt_accept_o)
		else $error("unsupported frame not discarded");
	a_mgmt_quiet: assert property (!mgmt_valid_i |=> !mgmt_accept_o && !mgmt_discard_o)
		else $error("filter pulse without frame");
	c_write: cover property (wb_ack_o && wb_we_i);
	c_error: cover property (wb_err_o);
	c_discard: cover property (mgmt_discard_o);
endmodule : rmms_mgmt_stats_chk
bind rmms_mgmt_stats rmms_mgmt_stats_chk i_rmms_mgmt_stats_chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
	.span_oper_i, .keepalive_ok_i, .peer_protect_i, .dup_mac_i, .mgmt_valid_i,
	.mgmt_frame_type_i, .mgmt_func_i, .mgmt_accept_o, .mgmt_discard_o, .pass_enable_o,
	.oper_up_o, .misconfig_o, .feature_dis_o);
`default_nettype wire

// file: tb/rmms_mgmt_stats_tb_top.sv
`default_nettype none
module rmms_mgmt_stats_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rmms_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0]  frame_done_i = 4'h0, frame_mcast_i = 4'h0;
	logic [7:0]  frame_class_i = 8'h00, span_err_i = 8'h00, topo_state_i = 8'h00;
	logic [63:0] frame_len_i = 64'h0;
	logic        interval_tick_i = 1'b0, span_oper_i = 1'b1, keepalive_ok_i = 1'b1;
	logic        peer_protect_i = 1'b0, dup_mac_i = 1'b0, mgmt_valid_i = 1'b0;
	logic [7:0]  mgmt_frame_type_i = 8'h00, mgmt_func_i = 8'h00, feature_dis_o;
	logic        mgmt_accept_o, mgmt_discard_o, pass_enable_o, oper_up_o, misconfig_o;
	int          n_errors = 0, comparisons = 0, cycles = 0;
	always #4 clk_i = ~clk_i;
	rmms_mgmt_stats i_rmms_mgmt_stats (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .frame_done_i,
		.frame_mcast_i, .frame_class_i, .frame_len_i, .span_err_i, .interval_tick_i,
		.span_oper_i, .keepalive_ok_i, .peer_protect_i, .dup_mac_i, .topo_state_i,
		.mgmt_valid_i, .mgmt_frame_type_i, .mgmt_func_i, .mgmt_accept_o, .mgmt_discard_o,
		.pass_enable_o, .oper_up_o, .misconfig_o, .feature_dis_o);
	rmms_station_mgr i_rmms_station_mgr (.clk_i, .ack_i(wb_ack_o), .err_i(wb_err_o),
		.dat_i(wb_dat_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i),
		.adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
	////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] v,
		input logic [31:0] exp, input logic eexp);
		logic [31:0] d;
		logic e;
		i_rmms_station_mgr.xfer(we, a, v, 4'hF, d, e);
		chk($sformatf("err at %h", a), {31'h0, eexp}, {31'h0, e});
		if (!we) chk($sformatf("data at %h", a), exp, d);
	endtask : acc
	function automatic logic [11:0] ca(input int per, input int idx);
		return 12'(12'h400 + 4 * (per * 128 + idx));
	endfunction : ca
	task automatic frame(input logic [3:0] pt, input logic [3:0] mc, input logic [7:0] cl,
		input logic [63:0] ln, input logic [7:0] er, input logic tk);
		@(posedge clk_i);
		frame_done_i <= pt;
		frame_mcast_i <= mc;
		frame_class_i <= cl;
		frame_len_i <= ln;
		span_err_i <= er;
		interval_tick_i <= tk;
		@(posedge clk_i);
		frame_done_i <= 4'h0;
		span_err_i <= 8'h00;
		interval_tick_i <= 1'b0;
	endtask : frame
	////////////////////////////////////////////////////////////
	task automatic t_state();
		acc(0, 12'h004, 0, 32'h0, 0);
		acc(1, 12'h000, 32'h1, 0, 0);
		chk("admin", 32'h1, {31'h0, pass_enable_o});
		repeat (2) @(posedge clk_i);
		chk("oper", 32'h1, {31'h0, oper_up_o});
		acc(0, 12'h004, 0, 32'h3, 0);
		@(posedge clk_i);
		span_oper_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		acc(0, 12'h004, 0, 32'h2, 0);
		@(posedge clk_i);
		span_oper_i <= 1'b1;
		peer_protect_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("oper protect", 32'h0, {31'h0, oper_up_o});
		peer_protect_i <= 1'b0;
		keepalive_ok_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("oper keepalive", 32'h0, {31'h0, oper_up_o});
		keepalive_ok_i <= 1'b1;
	endtask : t_state
	task automatic t_refuse();
		acc(1, 12'h004, 32'hFFFF_FFFF, 0, 1);
		acc(1, ca(0, 0), 32'h5, 0, 1);
		acc(0, 12'h01C, 0, 32'h0, 1);
		acc(0, ca(3, 0), 0, 32'h0, 1);
		acc(0, 12'h402, 0, 32'h0, 1);
		acc(0, ca(0, 72), 0, 32'h0, 1);
		acc(0, 12'h018, 0, 32'h1, 0);
		acc(0, 12'h004, 0, 32'h3, 0);
	endtask : t_refuse
	task automatic t_feat_dup();
		logic [31:0] d;
		logic        e;
		acc(1, 12'h00C, 32'hA5, 0, 0);
		chk("feature", 32'hA5, {24'h0, feature_dis_o});
		i_rmms_station_mgr.xfer(1, 12'h00C, 32'h5A, 4'hE, d, e);
		chk("feature lane err", 32'h0, {31'h0, e});
		chk("feature lane", 32'hA5, {24'h0, feature_dis_o});
		@(posedge clk_i);
		topo_state_i <= 8'h3C;
		acc(0, 12'h010, 0, 32'h3C, 0);
		@(posedge clk_i);
		dup_mac_i <= 1'b1;
		@(posedge clk_i);
		dup_mac_i <= 1'b0;
		@(negedge clk_i);
		chk("misconfig", 32'h1, {31'h0, misconfig_o});
		acc(0, 12'h008, 0, 32'h1, 0);
		acc(1, 12'h008, 32'h1, 0, 0);
		chk("misconfig clr", 32'h0, {31'h0, misconfig_o});
	endtask : t_feat_dup
	task automatic t_mgmt();
		logic [7:0] ty [4] = '{8'h03, 8'h02, 8'h00, 8'hFF};
		logic [7:0] fn [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			mgmt_valid_i <= 1'b1;
			mgmt_frame_type_i <= ty[i];
			mgmt_func_i <= fn[i];
			@(posedge clk_i);
			mgmt_valid_i <= 1'b0;
			@(negedge clk_i);
			chk("accept", {31'h0, i == 1}, {31'h0, mgmt_accept_o});
			chk("discard", {31'h0, i != 1}, {31'h0, mgmt_discard_o});
		end
		acc(0, 12'h014, 0, 32'h3, 0);
		acc(0, 12'h008, 0, 32'h2, 0);
	endtask : t_mgmt
	task automatic t_count();
		acc(1, 12'h000, 32'h3, 0, 0);
		acc(0, 12'h000, 0, 32'h1, 0);
		frame(4'h9, 4'h8, 8'hC1, 64'h0040_0000_0000_0064, 8'h81, 0);
		acc(0, ca(0, 2), 0, 32'h1, 0);
		acc(0, ca(0, 3), 0, 32'd100, 0);
		acc(0, ca(0, 62), 0, 32'h1, 0);
		acc(0, ca(0, 63), 0, 32'd64, 0);
		acc(0, ca(0, 10), 0, 32'h0, 0);
		acc(0, ca(0, 18), 0, 32'h0, 0);
		acc(0, ca(0, 64), 0, 32'h1, 0);
		acc(0, ca(0, 71), 0, 32'h1, 0);
		frame(4'h1, 4'h0, 8'h01, 64'h64, 8'h00, 0);
		acc(0, ca(0, 3), 0, 32'd200, 0);
	endtask : t_count
	task automatic t_interval();
		frame(4'h1, 4'h0, 8'h01, 64'h0A, 8'h00, 1);
		acc(0, ca(1, 2), 0, 32'h2, 0);
		acc(0, ca(2, 2), 0, 32'h2, 0);
		acc(0, ca(0, 2), 0, 32'h1, 0);
		acc(0, ca(0, 3), 0, 32'd10, 0);
		acc(0, ca(1, 71), 0, 32'h1, 0);
		acc(1, 12'h000, 32'h5, 0, 0);
		acc(0, ca(1, 2), 0, 32'h1, 0);
		acc(0, ca(2, 3), 0, 32'd210, 0);
		acc(0, ca(0, 2), 0, 32'h0, 0);
	endtask : t_interval
	////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("Mismatches %0d of %0d comparisons", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_state();
		t_refuse();
		t_feat_dup();
		t_mgmt();
		t_count();
		t_interval();
		summarize();
	end
endmodule : rmms_mgmt_stats_tb_top
`default_nettype wire
